// ---- design/ars_result_store.sv ----
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "ars_map.svh"

// What this block does
// - only last-result read clears result pending
// - enabled end stores result, sets pending
// - disabling other channel keeps pending set
// - disabled channel end stores nothing, no pending
// - other channel result read keeps pending set
// - end while pending sets global overrun
// - status read clears global overrun, set wins
// - result read keeps global overrun set
// - disabling other channel keeps global overrun
// - end with end flag set sets overrun
// - channel or last read clears end flag
// - status read clears channel overrun, set wins
// - no end flag for channel just disabled
// - channel read clears only its own flag
module ars_result_store #(
  parameter int NUM_CHAN = 8,
  parameter int DATA_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // conversion core
  input wire logic eocValid,
  input wire logic [$clog2(NUM_CHAN)-1:0] eocChan,
  input wire logic [DATA_W-1:0] eocData,
  // status levels
  output logic resultPending,
  output logic globalOverrun,
  output logic [NUM_CHAN-1:0] channelEnable
);

  localparam int CW = $clog2(NUM_CHAN);

  // address decode, shared by the write path and the read path
  function automatic ars_pkg::ars_regsel_t regSel(input logic [7:0] addr);
    ars_pkg::ars_regsel_t sel;
    sel = ars_pkg::ARS_SEL_NONE;
    if (addr == `ARS_OFF_CHAN_ENABLE)
    begin
      sel = ars_pkg::ARS_SEL_ENABLE;
    end
    else if (addr == `ARS_OFF_CHAN_DISABLE)
    begin
      sel = ars_pkg::ARS_SEL_DISABLE;
    end
    else if (addr == `ARS_OFF_CHAN_STATE)
    begin
      sel = ars_pkg::ARS_SEL_CHAN_STATE;
    end
    else if (addr == `ARS_OFF_STATUS)
    begin
      sel = ars_pkg::ARS_SEL_STATUS;
    end
    else if (addr == `ARS_OFF_LAST_RESULT)
    begin
      sel = ars_pkg::ARS_SEL_LAST;
    end
    else if (addr >= `ARS_OFF_CHAN_RESULT_BASE
             && addr < 8'(`ARS_OFF_CHAN_RESULT_BASE + 4 * NUM_CHAN)
             && addr[1:0] == 2'h0)
    begin
      sel = ars_pkg::ARS_SEL_CHAN_RESULT;
    end
    return sel;
  endfunction : regSel

  // one-hot channel picked by a channel-result address
  function automatic logic [NUM_CHAN-1:0] chanOfAddr(input logic [7:0] addr);
    logic [7:0] idx;
    logic [NUM_CHAN-1:0] hot;
    idx = 8'(addr - `ARS_OFF_CHAN_RESULT_BASE) >> 2;
    hot = '0;
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      if (idx == 8'(i))
      begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction : chanOfAddr

  ars_flag_if #(.NUM_CHAN(NUM_CHAN)) flagBus ();

  ars_chan_flags #(
    .NUM_CHAN(NUM_CHAN)
  ) u_flags (
    .clk_sys(clk_sys),
    .srst(srst),
    .fl(flagBus.flags)
  );

  logic [NUM_CHAN-1:0] chanEn_reg;
  logic [NUM_CHAN-1:0] chanEn_next;
  logic [DATA_W-1:0] chanResult_reg [NUM_CHAN];
  logic [DATA_W-1:0] chanResult_next [NUM_CHAN];
  logic [DATA_W-1:0] lastResult_reg;
  logic [DATA_W-1:0] lastResult_next;
  logic [CW-1:0] lastChan_reg;
  logic [CW-1:0] lastChan_next;
  logic pending_reg;
  logic pending_next;
  logic govr_reg;
  logic govr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  ars_pkg::ars_regsel_t sel;
  logic [NUM_CHAN-1:0] rdChanHot;
  logic [NUM_CHAN-1:0] disMask;
  logic [NUM_CHAN-1:0] eocHot;
  logic rdLast;
  logic rdStatus;
  logic accept;
  logic newGovr;

  // request decode
  always_comb
  begin
    sel = regSel(regAddr);
    rdChanHot = '0;
    if (regRead && sel == ars_pkg::ARS_SEL_CHAN_RESULT)
    begin
      rdChanHot = chanOfAddr(regAddr);
    end
    rdLast = regRead && sel == ars_pkg::ARS_SEL_LAST;
    rdStatus = regRead && sel == ars_pkg::ARS_SEL_STATUS;
    disMask = '0;
    if (regWrite && sel == ars_pkg::ARS_SEL_DISABLE)
    begin
      disMask = regWdata[NUM_CHAN-1:0];
    end
    eocHot = '0;
    if (eocValid && 32'(eocChan) < 32'(NUM_CHAN))
    begin
      eocHot[eocChan] = 1'b1;
    end
    // a channel disabled now or earlier gives no result
    accept = |(eocHot & chanEn_reg & ~disMask);
    newGovr = accept && pending_reg;
  end

  // flag requests to the per-channel flag store
  always_comb
  begin
    flagBus.setEoc = accept ? eocHot : '0;
    // only the addressed channel, plus the last channel on a last read
    flagBus.clrEoc = rdChanHot;
    if (rdLast)
    begin
      flagBus.clrEoc[lastChan_reg] = 1'b1;
    end
    flagBus.clrOvr = rdStatus;
  end

  // channel enables, results, last result and its channel
  always_comb
  begin
    chanEn_next = chanEn_reg;
    chanResult_next = chanResult_reg;
    lastResult_next = lastResult_reg;
    lastChan_next = lastChan_reg;
    if (regWrite && sel == ars_pkg::ARS_SEL_ENABLE)
    begin
      chanEn_next = chanEn_reg | regWdata[NUM_CHAN-1:0];
    end
    else if (regWrite && sel == ars_pkg::ARS_SEL_DISABLE)
    begin
      chanEn_next = chanEn_reg & ~regWdata[NUM_CHAN-1:0];
    end
    if (accept)
    begin
      chanResult_next[eocChan] = eocData;
      lastResult_next = eocData;
      lastChan_next = eocChan;
    end
  end

  // global flags: channel-result reads and disables never clear pending,
  // so a result stored beside them is always announced
  always_comb
  begin
    pending_next = pending_reg;
    if (rdLast)
    begin
      pending_next = 1'b0;
    end
    if (accept)
    begin
      pending_next = 1'b1;
    end
    if (rdStatus)
    begin
      govr_next = newGovr;
    end
    else
    begin
      govr_next = govr_reg | newGovr;
    end
  end

  // read data, sampled before this cycle's updates land
  always_comb
  begin
    rdata_next = `ARS_RDATA_RESET;
    if (regRead)
    begin
      case (sel)
        ars_pkg::ARS_SEL_CHAN_STATE:
        begin
          rdata_next[NUM_CHAN-1:0] = chanEn_reg;
        end
        ars_pkg::ARS_SEL_STATUS:
        begin
          rdata_next[`ARS_SR_EOC_LSB +: NUM_CHAN] = flagBus.eoc;
          rdata_next[`ARS_SR_OVR_LSB +: NUM_CHAN] = flagBus.ovr;
          rdata_next[`ARS_SR_PEND_BIT] = pending_reg;
          rdata_next[`ARS_SR_GOVR_BIT] = govr_reg;
        end
        ars_pkg::ARS_SEL_LAST:
        begin
          rdata_next[DATA_W-1:0] = lastResult_reg;
          rdata_next[`ARS_LR_CHAN_LSB +: CW] = lastChan_reg;
        end
        ars_pkg::ARS_SEL_CHAN_RESULT:
        begin
          for (int i = 0; i < NUM_CHAN; i++)
          begin
            if (rdChanHot[i])
            begin
              rdata_next[DATA_W-1:0] = chanResult_reg[i];
            end
          end
        end
        default:
        begin
          // write-only and unmapped addresses read as zero
          rdata_next = `ARS_RDATA_RESET;
        end
      endcase
    end
  end

  // channel enables and stored results
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      chanEn_reg <= NUM_CHAN'(`ARS_CHAN_EN_RESET);
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        chanResult_reg[i] <= '0;
      end
      lastResult_reg <= '0;
      lastChan_reg <= '0;
    end
    else
    begin
      chanEn_reg <= chanEn_next;
      chanResult_reg <= chanResult_next;
      lastResult_reg <= lastResult_next;
      lastChan_reg <= lastChan_next;
    end
  end

  // global flags
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pending_reg <= 1'b0;
      govr_reg <= 1'b0;
    end
    else
    begin
      pending_reg <= pending_next;
      govr_reg <= govr_next;
    end
  end

  // read data register, zero whenever no read was taken
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdata_reg <= `ARS_RDATA_RESET;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;
  assign resultPending = pending_reg;
  assign globalOverrun = govr_reg;
  assign channelEnable = chanEn_reg;

endmodule : ars_result_store

`default_nettype wire

// ---- shared/ars_map.svh ----
`ifndef ARS_MAP_SVH
`define ARS_MAP_SVH

// register offsets on the plain register port (byte addresses)
`define ARS_OFF_CHAN_ENABLE 8'h10
`define ARS_OFF_CHAN_DISABLE 8'h14
`define ARS_OFF_CHAN_STATE 8'h18
`define ARS_OFF_STATUS 8'h1c
`define ARS_OFF_LAST_RESULT 8'h20
`define ARS_OFF_CHAN_RESULT_BASE 8'h30

// status register fields
`define ARS_SR_EOC_LSB 0
`define ARS_SR_OVR_LSB 8
`define ARS_SR_PEND_BIT 16
`define ARS_SR_GOVR_BIT 17

// last-result register: channel number above the data
`define ARS_LR_CHAN_LSB 12

// reset values
`define ARS_CHAN_EN_RESET 32'h0000_0000
`define ARS_RDATA_RESET 32'h0000_0000

// read data appears this many cycles after the read strobe
`define ARS_READ_LATENCY 1

`endif

// ---- shared/ars_pkg.sv ----
package ars_pkg;

  // which register an address selects
  typedef enum logic [2:0] {
    ARS_SEL_NONE,
    ARS_SEL_ENABLE,
    ARS_SEL_DISABLE,
    ARS_SEL_CHAN_STATE,
    ARS_SEL_STATUS,
    ARS_SEL_LAST,
    ARS_SEL_CHAN_RESULT
  } ars_regsel_t;

endpackage : ars_pkg

// ---- shared/ars_flag_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface ars_flag_if #(
  parameter int NUM_CHAN = 8
);
  logic [NUM_CHAN-1:0] setEoc;
  logic [NUM_CHAN-1:0] clrEoc;
  logic clrOvr;
  logic [NUM_CHAN-1:0] eoc;
  logic [NUM_CHAN-1:0] ovr;

  modport ctl (
    output setEoc,
    output clrEoc,
    output clrOvr,
    input eoc,
    input ovr
  );

  modport flags (
    input setEoc,
    input clrEoc,
    input clrOvr,
    output eoc,
    output ovr
  );
endinterface : ars_flag_if

`default_nettype wire

// ---- design/ars_chan_flags.sv ----
`timescale 1ns/100ps
`default_nettype none

module ars_chan_flags #(
  parameter int NUM_CHAN = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // flag requests and flag state
  ars_flag_if.flags fl
);

  logic [NUM_CHAN-1:0] eoc_reg;
  logic [NUM_CHAN-1:0] eoc_next;
  logic [NUM_CHAN-1:0] ovr_reg;
  logic [NUM_CHAN-1:0] ovr_next;
  logic [NUM_CHAN-1:0] newOvr;

  always_comb
  begin
    // overrun judged on the flag as it stood before this cycle's clear
    newOvr = fl.setEoc & eoc_reg;
    // set wins over a clear in the same cycle
    eoc_next = (eoc_reg & ~fl.clrEoc) | fl.setEoc;
    if (fl.clrOvr)
    begin
      // status read drops old overruns even while a new end flag rises
      ovr_next = newOvr;
    end
    else
    begin
      ovr_next = ovr_reg | newOvr;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      eoc_reg <= '0;
      ovr_reg <= '0;
    end
    else
    begin
      eoc_reg <= eoc_next;
      ovr_reg <= ovr_next;
    end
  end

  assign fl.eoc = eoc_reg;
  assign fl.ovr = ovr_reg;

endmodule : ars_chan_flags

`default_nettype wire

// ---- dv/ars_result_store_checker.sv ----
`timescale 1ns/100ps
`default_nettype none

module ars_result_store_checker #(
  parameter int NUM_CHAN = 8,
  parameter int DATA_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  // conversion core
  input wire logic eocValid,
  input wire logic [$clog2(NUM_CHAN)-1:0] eocChan,
  input wire logic [DATA_W-1:0] eocData,
  // status levels
  input wire logic resultPending,
  input wire logic globalOverrun,
  input wire logic [NUM_CHAN-1:0] channelEnable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic acc;
  logic lastRd;
  logic statRd;
  logic [NUM_CHAN-1:0] wMask;
  assign wMask = regWdata[NUM_CHAN-1:0];
  assign lastRd = regRead && regAddr == 8'h20;
  assign statRd = regRead && regAddr == 8'h1c;
  // an end is dropped when its own channel is switched off in that cycle
  assign acc = eocValid && channelEnable[eocChan]
    && !(regWrite && regAddr == 8'h14 && regWdata[eocChan]);
  sequence endWhilePend;
    acc && resultPending;
  endsequence
  AST_PEND_SET: assert property (acc |=> resultPending)
    else $error("pending not set");
  AST_PEND_KEEP: assert property (resultPending && !lastRd |=> resultPending)
    else $error("pending lost");
  AST_PEND_DROP: assert property (lastRd && !acc |=> !resultPending)
    else $error("pending kept");
  AST_GOV_SET: assert property (endWhilePend |=> globalOverrun)
    else $error("overrun not set");
  AST_GOV_CLR: assert property (statRd && !(acc && resultPending) |=> !globalOverrun)
    else $error("overrun kept");
  AST_GOV_KEEP: assert property (globalOverrun && !statRd |=> globalOverrun)
    else $error("overrun lost");
  AST_GOV_SHOWN: assert property (statRd |=> regRdata[17] == $past(globalOverrun))
    else $error("overrun bit wrong");
  AST_RDATA_IDLE: assert property (!regRead |=> regRdata == '0)
    else $error("stray read data");
  AST_EN_CLR: assert property (regWrite && regAddr == 8'h14 |=> (channelEnable & $past(wMask)) == '0)
    else $error("disable ignored");
endmodule : ars_result_store_checker

bind ars_result_store ars_result_store_checker #(.NUM_CHAN(NUM_CHAN), .DATA_W(DATA_W)) chk (
  .clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .eocValid(eocValid),
  .eocChan(eocChan), .eocData(eocData), .resultPending(resultPending),
  .globalOverrun(globalOverrun), .channelEnable(channelEnable)
);

`default_nettype wire

// ---- dv/ars_conv_core.sv ----
`timescale 1ns/100ps
`default_nettype none

module ars_conv_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // start request
  input wire logic go,
  input wire logic [2:0] chan,
  input wire logic [9:0] data,
  input wire logic [3:0] lag,
  // end of conversion
  output logic eocValid,
  output logic [2:0] eocChan,
  output logic [9:0] eocData
);
  logic [3:0] cnt_reg;
  logic [2:0] ch_reg;
  logic [9:0] dat_reg;
  logic now;
  // zero lag answers in the same cycle so ends can coincide with accesses
  assign now = go && lag == 4'h0;
  always_ff @(posedge clk_sys)
  begin
    cnt_reg <= srst ? 4'h0 : (go ? lag : cnt_reg - 4'(cnt_reg != 4'h0));
    if (go || srst)
    begin
      ch_reg <= chan;
      dat_reg <= data;
    end
  end
  assign eocValid = now || cnt_reg == 4'h1;
  assign eocChan = now ? chan : ch_reg;
  // idle data shows the inverse so a stale value is never mistaken
  assign eocData = now ? data : (eocValid ? dat_reg : ~dat_reg);
endmodule : ars_conv_core

`default_nettype wire

// ---- dv/test_ars_result_store.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_ars_result_store;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic go = 1'b0;
  logic [2:0] chan = 3'h0;
  logic [9:0] data = 10'h0;
  logic [3:0] lag = 4'h0;
  logic eocValid;
  logic [2:0] eocChan;
  logic [9:0] eocData;
  logic resultPending;
  logic globalOverrun;
  logic [7:0] channelEnable;
  logic rdPend_reg = 1'b0;
  logic [31:0] expQ[$];
  logic [9:0] dv[8] = '{default: 10'h0};
  integer seed = 32'h9f931b3a;
  int fails = 0;
  int total_checks = 0;

  ars_result_store dut (
    .clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .eocValid(eocValid),
    .eocChan(eocChan), .eocData(eocData), .resultPending(resultPending),
    .globalOverrun(globalOverrun), .channelEnable(channelEnable)
  );
  ars_conv_core core (
    .clk_sys(clk_sys), .srst(srst), .go(go), .chan(chan), .data(data), .lag(lag),
    .eocValid(eocValid), .eocChan(eocChan), .eocData(eocData)
  );

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  function automatic logic [31:0] st(input logic [7:0] e, input logic [7:0] o,
    input logic p, input logic g);
    return {14'h0, g, p, o, e};
  endfunction : st

  function automatic logic [31:0] lr(input int c);
    return (32'(c) << 12) | 32'(dv[c]);
  endfunction : lr

  // one bus cycle plus an optional conversion start, ending in the same cycle when lag is zero
  task automatic s(input int op, input logic [7:0] a, input logic [31:0] x,
    input bit g, input int c);
    regRead <= op == 1;
    regWrite <= op == 2;
    regAddr <= a;
    regWdata <= x;
    if (op == 1)
      expQ.push_back(x);
    if (g)
      dv[c] = 10'($random(seed));
    go <= g;
    chan <= 3'(c);
    data <= dv[c];
    @(posedge clk_sys);
  endtask : s

  always @(posedge clk_sys)
  begin
    if (rdPend_reg)
      chk(regRdata, expQ.pop_front());
    rdPend_reg <= regRead;
  end

  initial
  begin
    #(3000 * 10);
    fails++;
    end_sim();
  end

  initial
  begin
    int c;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    s(1, 8'h1c, 0, 0, 0);
    s(1, 8'h04, 0, 0, 0);
    s(2, 8'h10, 32'hff, 0, 0);
    s(1, 8'h18, 32'hff, 1, 2);
    s(1, 8'h38, {22'h0, dv[2]}, 0, 0);
    s(1, 8'h1c, st(8'h00, 8'h00, 1, 0), 0, 0);
    s(0, 8'h00, 0, 1, 2);
    s(1, 8'h44, 0, 1, 2);
    s(1, 8'h1c, st(8'h04, 8'h04, 1, 1), 0, 0);
    s(1, 8'h1c, st(8'h04, 8'h00, 1, 0), 0, 0);
    s(1, 8'h20, lr(2), 0, 0);
    s(1, 8'h1c, st(8'h00, 8'h00, 0, 0), 0, 0);
    s(0, 8'h00, 0, 1, 2);
    s(1, 8'h1c, st(8'h04, 8'h00, 1, 0), 1, 4);
    s(1, 8'h1c, st(8'h14, 8'h00, 1, 1), 0, 0);
    s(0, 8'h00, 0, 1, 4);
    s(1, 8'h40, {22'h0, dv[4]}, 0, 0);
    s(1, 8'h1c, st(8'h04, 8'h10, 1, 1), 1, 4);
    s(1, 8'h1c, st(8'h14, 8'h00, 1, 1), 0, 0);
    s(2, 8'h14, 32'h40, 1, 4);
    s(1, 8'h1c, st(8'h14, 8'h10, 1, 1), 0, 0);
    s(1, 8'h18, 32'hbf, 0, 0);
    s(1, 8'h20, lr(4), 1, 6);
    s(1, 8'h1c, st(8'h04, 8'h00, 0, 0), 0, 0);
    s(1, 8'h48, 0, 0, 0);
    // pending is low here, so these show the set rather than a kept level
    s(1, 8'h44, 0, 1, 2);
    s(1, 8'h1c, st(8'h04, 8'h04, 1, 0), 0, 0);
    s(1, 8'h20, lr(2), 0, 0);
    s(2, 8'h14, 32'h01, 1, 3);
    s(1, 8'h1c, st(8'h08, 8'h00, 1, 0), 0, 0);
    s(2, 8'h10, 32'h01, 0, 0);
    s(0, 8'h00, 0, 0, 0);
    $display("test directed done");
    lag <= 4'h3;
    for (int i = 0; i < 8; i++)
    begin
      c = $random(seed) & 7;
      if (c == 6)
        c = 7;
      s(0, 8'h00, 0, 1, c);
      repeat (4) s(0, 8'h00, 0, 0, 0);
      s(1, 8'h30 + 8'(4 * c), {22'h0, dv[c]}, 0, 0);
    end
    repeat (3) s(0, 8'h00, 0, 0, 0);
    $display("test random done");
    end_sim();
  end
endmodule : test_ars_result_store

`default_nettype wire
